// >>> src/supervision_timer.sv
// windowed supervision timer with avalon-mm register slave
//
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module supervision_timer (
  input wire logic clk_sys,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // low-speed oscillators
  input wire logic lowSpeedInternalOsc,
  input wire logic lowSpeedCrystalOsc,
  // processor halted by debugger, same clock
  input wire logic cpuDebugHalted,
  // outputs to the system
  output logic irq,
  output logic sysResetReq
);

  //////////////////////////////////////////////////////////////////////
  // declarations

  // configuration and data registers
  sup_timer_pkg::ctrl_s ctrl_reg;
  sup_timer_pkg::ctrl_s ctrl_next;
  logic [11:0] reload_reg; // counter value register
  logic [11:0] reload_next;
  logic [11:0] delta_reg; // window threshold
  logic [11:0] delta_next;
  logic lock_reg; // configuration write lock
  logic lock_next;

  // counting state
  logic [11:0] count_reg;
  logic [11:0] count_next;
  logic [6:0] pre_reg; // prescaler counter
  logic [6:0] pre_next;

  // events and interrupt
  logic [2:0] status_reg;
  logic [2:0] status_next;
  logic [2:0] irqEn_reg;
  logic [2:0] irqEn_next;
  logic irq_next;
  logic sysResetReq_next;

  // bus handshake
  logic [31:0] readdata_next;
  logic waitrequest_next;

  // oscillator ticks
  logic tickInt;
  logic tickXtal;
  logic oscTick;

  // decode wires
  logic busReq;
  logic accept;
  logic wrAccept;
  logic wrCtrl;
  logic wrReload;
  logic wrDelta;
  logic wrKick;
  logic wrLock;
  logic wrClear;
  logic wrIrqEn;
  logic protWrite;
  logic blockedWrite;
  logic lowHalf;
  logic [15:0] keyData;
  logic selCtrl; // address matches, one per writable register
  logic selReload;
  logic selDelta;
  logic selKick;
  logic selLock;
  logic selClear;
  logic selIrqEn;
  logic isKickKey; // key word compares
  logic isLockKey;
  logic isUnlockKey;
  logic [2:0] clearMask; // status bits software clears this cycle

  // counting wires
  logic frozen;
  logic [6:0] preMask;
  logic preWrap;
  logic countTick;
  logic underflow;
  logic kickValid;
  logic kickEarly;
  logic failEvent;
  logic reloadNow; // restore count, clear prescaler
  logic [2:0] events;
  logic [31:0] readMux;

  //////////////////////////////////////////////////////////////////////
  // functions

  // zero-extend a 12-bit field into a bus word
  function automatic logic [31:0] word12(input logic [11:0] v);
    word12 = {20'h0000_0, v};
  endfunction

  // all-ones mask of width psc for the prescaler compare
  function automatic logic [6:0] psc_mask(input logic [2:0] psc);
    psc_mask = 7'((8'h01 << psc) - 8'h01);
  endfunction

  //////////////////////////////////////////////////////////////////////
  // oscillator synchronisers

  // internal oscillator edges
  osc_tick_sync u_sync_int (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .oscIn(lowSpeedInternalOsc),
    .tick(tickInt)
  );

  // crystal oscillator edges
  osc_tick_sync u_sync_xtal (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .oscIn(lowSpeedCrystalOsc),
    .tick(tickXtal)
  );

  // counting time base comes from a low-speed oscillator
  assign oscTick = ctrl_reg.clkSel ? tickXtal : tickInt;

  //////////////////////////////////////////////////////////////////////
  // bus decode

  // request seen while waitrequest high, completed when it drops
  assign busReq = avs_read | avs_write;
  assign accept = busReq & ~avs_waitrequest;
  assign wrAccept = accept & avs_write;
  // keys need both low byte lanes
  assign lowHalf = avs_byteenable[0] & avs_byteenable[1];
  assign keyData = avs_writedata[15:0];

  // address decode of the writable offsets
  assign selCtrl = (avs_address == sup_timer_pkg::OFS_CTRL);
  assign selReload = (avs_address == sup_timer_pkg::OFS_RELOAD);
  assign selDelta = (avs_address == sup_timer_pkg::OFS_DELTA);
  assign selKick = (avs_address == sup_timer_pkg::OFS_KICK);
  assign selLock = (avs_address == sup_timer_pkg::OFS_LOCK);
  assign selClear = (avs_address == sup_timer_pkg::OFS_CLEAR);
  assign selIrqEn = (avs_address == sup_timer_pkg::OFS_IRQEN);

  // key words, only honoured with both low lanes
  assign isKickKey = (keyData == sup_timer_pkg::KICK_KEY);
  assign isLockKey = (keyData == sup_timer_pkg::LOCK_KEY);
  assign isUnlockKey = (keyData == sup_timer_pkg::UNLOCK_KEY);

  // per-register write strobes
  assign wrCtrl = wrAccept & selCtrl;
  assign wrReload = wrAccept & selReload;
  assign wrDelta = wrAccept & selDelta;
  assign wrKick = wrAccept & selKick & lowHalf & isKickKey;
  assign wrLock = wrAccept & selLock & lowHalf;
  assign wrClear = wrAccept & selClear & avs_byteenable[0];
  assign wrIrqEn = wrAccept & selIrqEn & avs_byteenable[0];

  // configuration writes are dropped while locked
  assign protWrite = wrCtrl | wrReload | wrDelta;
  assign blockedWrite = protWrite & lock_reg;

  //////////////////////////////////////////////////////////////////////
  // register next values

  // control register, low byte only
  assign ctrl_next = (wrCtrl & ~lock_reg & avs_byteenable[0])
                     ? sup_timer_pkg::ctrl_s'(avs_writedata[6:0]) : ctrl_reg;

  // counter value register, 12 bits over two lanes
  always_comb begin
    reload_next = reload_reg;
    if (wrReload & ~lock_reg) begin
      if (avs_byteenable[0]) begin
        reload_next[7:0] = avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
        reload_next[11:8] = avs_writedata[11:8];
      end
    end
  end

  // delta value register, same layout
  always_comb begin
    delta_next = delta_reg;
    if (wrDelta & ~lock_reg) begin
      if (avs_byteenable[0]) begin
        delta_next[7:0] = avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
        delta_next[11:8] = avs_writedata[11:8];
      end
    end
  end

  // lock set and cleared by key words, others ignored
  always_comb begin
    lock_next = lock_reg;
    if (wrLock && isLockKey) begin
      lock_next = 1'b1;
    end else if (wrLock && isUnlockKey) begin
      lock_next = 1'b0;
    end
  end

  // interrupt enable, same layout as status
  assign irqEn_next = wrIrqEn ? avs_writedata[2:0] : irqEn_reg;

  //////////////////////////////////////////////////////////////////////
  // prescaler and counter

  // debug freeze stops prescaler and counter alike
  assign frozen = ctrl_reg.dbgHalt & cpuDebugHalted;

  // divide oscillator ticks by 2**psc
  assign preMask = psc_mask(ctrl_reg.psc);
  assign preWrap = (pre_reg & preMask) == preMask;
  assign countTick = ctrl_reg.enable & ~frozen & oscTick & preWrap;

  // counting through zero without a reload is a failure
  assign underflow = countTick & (count_reg == 12'h000);

  // reload inside the window versus too early
  assign kickValid = wrKick & ctrl_reg.enable & (count_reg < delta_reg);
  assign kickEarly = wrKick & ctrl_reg.enable & (count_reg >= delta_reg);
  assign failEvent = underflow | kickEarly;
  // disabled, any kick, early or not, and underflow all reload
  assign reloadNow = ~ctrl_reg.enable | kickValid | kickEarly | underflow;

  // prescaler counts ticks, cleared on any reload
  always_comb begin
    pre_next = pre_reg;
    if (reloadNow) begin
      pre_next = 7'h00;
    end else if (oscTick && !frozen) begin
      pre_next = preWrap ? 7'h00 : 7'(pre_reg + 7'h01);
    end
  end

  // down counter, restored from the counter value register
  always_comb begin
    count_next = count_reg;
    if (reloadNow) begin
      count_next = reload_reg;
    end else if (countTick) begin
      count_next = count_reg - 12'h001;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // events, interrupt and reset

  // sticky events
  assign events = {blockedWrite, kickEarly, underflow};

  // bits written as one by software, none on other cycles
  assign clearMask = wrClear ? avs_writedata[2:0] : 3'h0;
  // set wins over a clear in the same cycle
  assign status_next = (status_reg & ~clearMask) | events;

  // interrupt only in interrupt mode
  assign irq_next = |(status_next & irqEn_next)
                    & (ctrl_next.mode == sup_timer_pkg::RESP_IRQ);

  // reset request latches until the system reset arrives
  assign sysResetReq_next = sysResetReq
                            | (failEvent & (ctrl_reg.mode == sup_timer_pkg::RESP_RESET));

  //////////////////////////////////////////////////////////////////////
  // read mux and handshake

  // unmapped and write-only offsets read as zero
  always_comb begin
    unique case (avs_address)
      sup_timer_pkg::OFS_CTRL: readMux = {25'h000_0000, ctrl_reg};
      sup_timer_pkg::OFS_RELOAD: readMux = word12(reload_reg);
      sup_timer_pkg::OFS_DELTA: readMux = word12(delta_reg);
      sup_timer_pkg::OFS_LOCK: readMux = {31'h0000_0000, lock_reg};
      sup_timer_pkg::OFS_COUNT: readMux = word12(count_reg);
      sup_timer_pkg::OFS_STATUS: readMux = {29'h0000_0000, status_reg};
      sup_timer_pkg::OFS_IRQEN: readMux = {29'h0000_0000, irqEn_reg};
      default: readMux = 32'h0000_0000;
    endcase
  end

  // one wait cycle, then waitrequest low for one cycle
  assign waitrequest_next = ~(busReq & avs_waitrequest);
  assign readdata_next = (avs_read & avs_waitrequest) ? readMux : avs_readdata;

  //////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_reg <= sup_timer_pkg::CTRL_RST;
      reload_reg <= sup_timer_pkg::RELOAD_RST;
      delta_reg <= sup_timer_pkg::DELTA_RST;
      lock_reg <= 1'b0;
      irqEn_reg <= 3'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      reload_reg <= reload_next;
      delta_reg <= delta_next;
      lock_reg <= lock_next;
      irqEn_reg <= irqEn_next;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // counting state and events
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      count_reg <= sup_timer_pkg::RELOAD_RST;
      pre_reg <= 7'h00;
      status_reg <= 3'h0;
    end else begin
      count_reg <= count_next;
      pre_reg <= pre_next;
      status_reg <= status_next;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq <= 1'b0;
      sysResetReq <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      irq <= irq_next;
      sysResetReq <= sysResetReq_next;
      avs_waitrequest <= waitrequest_next;
      avs_readdata <= readdata_next;
    end
  end

endmodule

// >>> inc/sup_timer_pkg.sv
// constants, types and register map of the windowed supervision timer
// Summary of operation
// - 12-bit down counter fed by 7-bit prescaler
// - failure response is interrupt or system reset
// - underflow without reload raises selected response
// - reload at count >= delta is a failure
// - optional counter halt while processor is debugged
// - enableable lock blocks configuration writes
// - reload value and delta held in registers
// - counts on a low-speed oscillator, not sysclk
package sup_timer_pkg;

  //////////////////////////////////////////////////////////////////////
  // widths
  localparam int CNT_W = 12;
  localparam int PSC_W = 3;
  localparam int PRE_W = 7;
  localparam int ADDR_W = 6;

  //////////////////////////////////////////////////////////////////////
  // byte offsets on the register bus
  localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_RELOAD = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_DELTA = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_KICK = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_LOCK = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_CLEAR = 6'h1C;
  localparam logic [ADDR_W-1:0] OFS_IRQEN = 6'h20;

  //////////////////////////////////////////////////////////////////////
  // key values written by software
  localparam logic [15:0] KICK_KEY = 16'h5FA0;
  localparam logic [15:0] LOCK_KEY = 16'h35CA;
  localparam logic [15:0] UNLOCK_KEY = 16'h53CA;

  //////////////////////////////////////////////////////////////////////
  // status bit positions
  localparam int ST_UNDER = 0;
  localparam int ST_EARLY = 1;
  localparam int ST_BLOCKED = 2;
  localparam int ST_W = 3;

  //////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [CNT_W-1:0] RELOAD_RST = 12'hFFF;
  localparam logic [CNT_W-1:0] DELTA_RST = 12'hFFF;
  localparam logic [PSC_W-1:0] PSC_RST = 3'h0;

  // failure response
  typedef enum logic {
    RESP_IRQ,
    RESP_RESET
  } resp_e;

  // control register layout, bit 6 downward
  typedef struct packed {
    logic [PSC_W-1:0] psc;     // bits 6:4, divide by 2**psc
    logic clkSel;              // bit 3, 0 internal osc, 1 crystal osc
    logic dbgHalt;             // bit 2, freeze in debug
    resp_e mode;               // bit 1
    logic enable;              // bit 0
  } ctrl_s;

  localparam ctrl_s CTRL_RST = '{psc: PSC_RST, clkSel: 1'b0, dbgHalt: 1'b0,
                                 mode: RESP_IRQ, enable: 1'b0};

endpackage

// >>> src/osc_tick_sync.sv
// three-stage synchroniser turning a slow oscillator into rising-edge ticks
`timescale 1ns/1ps
module osc_tick_sync (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic oscIn,
  output logic tick
);

  logic s1Reg; // first stage, read only by s2Reg
  logic s2Reg;
  logic s3Reg;
  logic levelReg; // accepted level
  logic levelNext;
  logic agree;

  // accept a change only when stages two and three agree
  assign agree = (s2Reg == s3Reg);
  assign levelNext = agree ? s3Reg : levelReg;

  ////////////////////////////////////////////////////////////////////
  // shift chain and accepted level
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s1Reg <= 1'b0;
      s2Reg <= 1'b0;
      s3Reg <= 1'b0;
      levelReg <= 1'b0;
      tick <= 1'b0;
    end else begin
      s1Reg <= oscIn;
      s2Reg <= s1Reg;
      s3Reg <= s2Reg;
      levelReg <= levelNext;
      tick <= levelNext & ~levelReg; // one pulse per rising edge
    end
  end

endmodule

// >>> sim/supervision_timer_sva.sv
// assertion checker on the supervision timer ports
`timescale 1ns/1ps
module supervision_timer_sva (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic irq,
  input wire logic sysResetReq
);
  // one clock domain, quiet while reset is low
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////
  // request seen while the slave waits
  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  // one-cycle completion, then idle again
  sequence s_done;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  property p_take; s_taken |=> s_done; endproperty
  property p_cause;
    !avs_waitrequest |-> $past((avs_read || avs_write) && avs_waitrequest);
  endproperty
  property p_idle; avs_waitrequest && !avs_read && !avs_write |=> avs_waitrequest; endproperty
  property p_rdhold; !$stable(avs_readdata) |-> $past(avs_read && avs_waitrequest); endproperty
  property p_sticky; sysResetReq |=> sysResetReq; endproperty
  property p_rstval;
    $rose(rst_n) |-> !irq && !sysResetReq && avs_waitrequest && avs_readdata == 32'h0000_0000;
  endproperty
  property p_irqfall; $fell(irq) |-> $past(avs_write && !avs_waitrequest); endproperty
  property p_excl; $rose(sysResetReq) |-> !irq; endproperty
  ////////////////////////////////////////////////////////////////////
  a_take: assert property (p_take) else $error("bus request not answered in one cycle");
  a_cause: assert property (p_cause) else $error("completion without a request");
  a_idle: assert property (p_idle) else $error("waitrequest dropped while idle");
  a_rdhold: assert property (p_rdhold) else $error("read data moved without a read");
  a_sticky: assert property (p_sticky) else $error("reset request released early");
  a_rstval: assert property (p_rstval) else $error("outputs not at reset values");
  a_irqfall: assert property (p_irqfall) else $error("irq fell without a write");
  a_excl: assert property (p_excl) else $error("irq high in reset response");
endmodule
bind supervision_timer supervision_timer_sva chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq(irq), .sysResetReq(sysResetReq));

// >>> sim/testbench.sv
// self-checking bench for the windowed supervision timer
`timescale 1ns/1ps
module testbench;
  logic clk_sys;
  logic rst_n;
  logic [5:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic oscInt; // internal slow oscillator
  logic oscXtal; // crystal slow oscillator
  logic oscRun = 1'b1; // internal oscillator running
  logic cpuDebugHalted;
  logic irq;
  logic sysResetReq;
  logic [31:0] seed; // lfsr state
  logic [11:0] val; // reload value held in the block
  logic [31:0] expQ[$]; // expected read data
  string nameQ[$]; // what each note checks
  int miscompares;
  int checksDone;
  int oscCnt = 0;
  int n;

  supervision_timer uut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .lowSpeedInternalOsc(oscInt),
    .lowSpeedCrystalOsc(oscXtal), .cpuDebugHalted(cpuDebugHalted), .irq(irq),
    .sysResetReq(sysResetReq));

  ////////////////////////////////////////////////////////////////////
  // 40 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // slow oscillators: internal ticks every 8 clocks, crystal every 12
  always @(posedge clk_sys) begin
    oscCnt <= oscCnt + 1;
    if (oscRun && oscCnt % 4 == 0) oscInt <= ~oscInt;
    if (oscCnt % 6 == 0) oscXtal <= ~oscXtal;
  end
  // watcher: each finished read takes the oldest note
  always @(posedge clk_sys) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) cmp(nameQ.pop_front(), expQ.pop_front(),
      avs_readdata);
  end

  ////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
    checksDone++;
  endtask
  task automatic wrap_up();
    if (miscompares == 0 && checksDone > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge clk_sys);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    if (avs_waitrequest !== 1'b0) begin
      miscompares++;
      wrap_up();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e, input string nm);
    expQ.push_back(e);
    nameQ.push_back(nm);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  // bounded wait for irq or the reset request
  task automatic waitp(input logic rs, input int lim, output int cyc);
    cyc = 0;
    while ((rs ? sysResetReq : irq) !== 1'b1 && cyc < lim) begin
      @(posedge clk_sys);
      cyc++;
    end
    if ((rs ? sysResetReq : irq) !== 1'b1) begin
      miscompares++;
      wrap_up();
    end
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    oscInt = 1'b0;
    oscXtal = 1'b0;
    cpuDebugHalted = 1'b0;
    seed = 32'h0000_eda0;
    miscompares = 0;
    checksDone = 0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    // reset values, unmapped 0x24 last
    for (n = 0; n < 10; n++) begin
      if (n % 4 != 3) rd(6'(n * 4), (n == 1 || n == 2 || n == 5) ? 32'h0000_0FFF : 0, "reset");
    end
    // random readback of reload and delta
    for (n = 0; n < 4; n++) begin
      seed = lfsr(seed);
      val = seed[11:0];
      wr(sup_timer_pkg::OFS_RELOAD, seed);
      rd(sup_timer_pkg::OFS_RELOAD, 32'(val), "reload");
      wr(sup_timer_pkg::OFS_DELTA, ~seed);
      rd(sup_timer_pkg::OFS_DELTA, {20'h0_0000, ~val}, "delta");
    end
    // byte lane 0 only
    avs_byteenable <= 4'h1;
    wr(sup_timer_pkg::OFS_RELOAD, 32'h0000_0ABC);
    avs_byteenable <= 4'hF;
    val = {val[11:8], 8'hBC};
    rd(sup_timer_pkg::OFS_RELOAD, 32'(val), "reload lane");
    // locked configuration refuses writes
    wr(sup_timer_pkg::OFS_LOCK, 32'(sup_timer_pkg::LOCK_KEY));
    rd(sup_timer_pkg::OFS_LOCK, 32'h0000_0001, "lock");
    wr(sup_timer_pkg::OFS_RELOAD, 32'h0000_0123);
    rd(sup_timer_pkg::OFS_RELOAD, 32'(val), "locked reload");
    rd(sup_timer_pkg::OFS_STATUS, 32'h1 << sup_timer_pkg::ST_BLOCKED, "blocked");
    wr(sup_timer_pkg::OFS_LOCK, 32'(sup_timer_pkg::UNLOCK_KEY));
    wr(sup_timer_pkg::OFS_CLEAR, 32'h0000_0007);
    // underflow: reload 3, psc 1, 8 ticks of 8 clocks
    wr(sup_timer_pkg::OFS_RELOAD, 32'h0000_0003);
    wr(sup_timer_pkg::OFS_IRQEN, 32'h0000_0001);
    wr(sup_timer_pkg::OFS_CTRL, 32'h0000_0011);
    waitp(1'b0, 200, n);
    cmp("underflow time", 1, 32'(n >= 48 && n <= 80));
    rd(sup_timer_pkg::OFS_STATUS, 32'h1 << sup_timer_pkg::ST_UNDER, "underflow");
    wr(sup_timer_pkg::OFS_IRQEN, 32'h0000_0000);
    cmp("irq masked", 0, 32'(irq));
    wr(sup_timer_pkg::OFS_CTRL, 32'h0000_0000);
    wr(sup_timer_pkg::OFS_CLEAR, 32'h0000_0007);
    wr(sup_timer_pkg::OFS_IRQEN, 32'h0000_0003);
    cmp("irq cleared", 0, 32'(irq));
    // early kick, then a kick inside the window
    wr(sup_timer_pkg::OFS_RELOAD, 32'h0000_000C);
    wr(sup_timer_pkg::OFS_DELTA, 32'h0000_0008);
    wr(sup_timer_pkg::OFS_CTRL, 32'h0000_0021);
    wr(sup_timer_pkg::OFS_KICK, 32'(sup_timer_pkg::KICK_KEY));
    rd(sup_timer_pkg::OFS_STATUS, 32'h1 << sup_timer_pkg::ST_EARLY, "early");
    cmp("irq early", 1, 32'(irq));
    repeat (260) @(posedge clk_sys);
    wr(sup_timer_pkg::OFS_KICK, 32'(sup_timer_pkg::KICK_KEY));
    rd(sup_timer_pkg::OFS_COUNT, 32'h0000_000C, "count reload");
    rd(sup_timer_pkg::OFS_STATUS, 32'h1 << sup_timer_pkg::ST_EARLY, "window kick");
    // reset response, then a reset in mid-run
    wr(sup_timer_pkg::OFS_RELOAD, 32'h0000_0002);
    wr(sup_timer_pkg::OFS_CTRL, 32'h0000_0003);
    waitp(1'b1, 200, n);
    cmp("irq in reset mode", 0, 32'(irq));
    rst_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    cmp("reset request", 0, 32'(sysResetReq));
    // debug halt freezes the count
    cpuDebugHalted <= 1'b1;
    wr(sup_timer_pkg::OFS_CTRL, 32'h0000_0005);
    repeat (100) @(posedge clk_sys);
    rd(sup_timer_pkg::OFS_COUNT, 32'h0000_0FFF, "halted count");
    cpuDebugHalted <= 1'b0;
    // crystal source with the internal one stopped
    // disable first so the count follows the short reload value
    oscRun <= 1'b0;
    wr(sup_timer_pkg::OFS_CTRL, 32'h0000_0000);
    wr(sup_timer_pkg::OFS_RELOAD, 32'h0000_0002);
    wr(sup_timer_pkg::OFS_IRQEN, 32'h0000_0001);
    wr(sup_timer_pkg::OFS_CTRL, 32'h0000_0009);
    waitp(1'b0, 200, n);
    cmp("crystal time", 1, 32'(n >= 16 && n <= 48));
    wrap_up();
  end
endmodule
